// ---- design/wdrc_core.v ----
// Watchdog timer, guarded control, brown-out supervisor and reset sequencing with APB access
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "wdrc_regs.vh"

module wdrc_core (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        slow_internal_osc,
    input  wire        supply_low,
    input  wire        low_power_mode,
    input  wire        kick_instruction,
    input  wire        halt_instruction,
    output wire        sys_reset,
    output reg         pc_sp_clear,
    output wire [7:0]  port_data,
    output wire [7:0]  port_dir
);

    reg  [7:0]  watchdog_control_q;
    reg  [2:0]  reset_cause_flags_q;
    reg  [7:0]  brownout_threshold_select_q;
    reg  [1:0]  filter_time_select_q;
    reg         watchdog_expired_flag_q;
    reg         powerdown_flag_q;
    reg  [7:0]  port_data_q;
    reg  [7:0]  port_dir_q;

    reg         osc_s1_q;
    reg         osc_s2_q;
    reg         osc_s3_q;
    reg         low_s1_q;
    reg         low_s2_q;

    reg  [17:0] wdt_cnt_q;
    reg  [7:0]  bo_cnt_q;
    reg  [7:0]  key_dly_q;
    reg  [7:0]  code_dly_q;
    reg  [2:0]  hold_q;
    reg         sys_reset_q;

    wire        apb_wr;
    wire        mapped;
    wire        slow_tick;
    wire [4:0]  guard_key;
    wire        key_ok;
    wire        code_ok;
    wire [17:0] wdt_last;
    wire        wdt_ovf;
    wire [7:0]  bo_last;
    wire        bo_fire;
    wire        key_fire;
    wire        code_fire;
    wire        full_rst;
    wire        wr_ctrl;
    wire        wr_cause;
    wire        wr_thresh;
    wire        wr_filter;
    wire        wr_pdata;
    wire        wr_pdir;
    reg  [31:0] rd_mux;

    // Terminal count of the watchdog for each period code
    function [17:0] wdrc_period_last;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    wdrc_period_last = 18'h000ff;
                3'h1:    wdrc_period_last = 18'h003ff;
                3'h2:    wdrc_period_last = 18'h00fff;
                3'h3:    wdrc_period_last = 18'h03fff;
                3'h4:    wdrc_period_last = 18'h07fff;
                3'h5:    wdrc_period_last = 18'h0ffff;
                3'h6:    wdrc_period_last = 18'h1ffff;
                default: wdrc_period_last = 18'h3ffff;
            endcase
        end
    endfunction

    // Supply-low episode must outlast this many slow ticks
    function [7:0] wdrc_filter_last;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    wdrc_filter_last = 8'h07;
                2'h1:    wdrc_filter_last = 8'h1f;
                2'h2:    wdrc_filter_last = 8'h3f;
                default: wdrc_filter_last = 8'h7f;
            endcase
        end
    endfunction

    // APB slave: zero wait states while enabled, error on holes in the map
    assign pready    = clk_en;
    assign apb_wr    = psel & penable & pwrite & clk_en;
    assign mapped    = (paddr == `WDRC_OFF_CTRL)      | (paddr == `WDRC_OFF_CAUSE)  |
                       (paddr == `WDRC_OFF_THRESH)    | (paddr == `WDRC_OFF_FILTER) |
                       (paddr == `WDRC_OFF_STATUS)    | (paddr == `WDRC_OFF_PORT_DATA) |
                       (paddr == `WDRC_OFF_PORT_DIR);
    assign pslverr   = psel & penable & ~mapped;
    assign wr_ctrl   = apb_wr & (paddr == `WDRC_OFF_CTRL);
    assign wr_cause  = apb_wr & (paddr == `WDRC_OFF_CAUSE);
    assign wr_thresh = apb_wr & (paddr == `WDRC_OFF_THRESH);
    assign wr_filter = apb_wr & (paddr == `WDRC_OFF_FILTER);
    assign wr_pdata  = apb_wr & (paddr == `WDRC_OFF_PORT_DATA);
    assign wr_pdir   = apb_wr & (paddr == `WDRC_OFF_PORT_DIR);

    always @* begin
        rd_mux = 32'h0;
        case (paddr)
            `WDRC_OFF_CTRL:      rd_mux = {24'h0, watchdog_control_q};
            `WDRC_OFF_CAUSE:     rd_mux = {29'h0, reset_cause_flags_q};
            `WDRC_OFF_THRESH:    rd_mux = {24'h0, brownout_threshold_select_q};
            `WDRC_OFF_FILTER:    rd_mux = {30'h0, filter_time_select_q};
            `WDRC_OFF_STATUS:    rd_mux = {29'h0, sys_reset_q, powerdown_flag_q,
                                           watchdog_expired_flag_q};
            `WDRC_OFF_PORT_DATA: rd_mux = {24'h0, port_data_q};
            `WDRC_OFF_PORT_DIR:  rd_mux = {24'h0, port_dir_q};
            default:             rd_mux = 32'h0;
        endcase
    end

    // Read data is captured in the enabled setup cycle so it is stable in the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (clk_en && psel && !penable) begin
            prdata <= rd_mux;
        end
    end

    // Oscillator and supply pins come from outside the pclk domain
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
            low_s1_q <= 1'b0;
            low_s2_q <= 1'b0;
        end else if (clk_en) begin
            osc_s1_q <= slow_internal_osc;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
            low_s1_q <= supply_low;
            low_s2_q <= low_s1_q;
        end
    end

    // Count is independent of the system clock choice: one step per oscillator rise
    assign slow_tick = osc_s2_q & ~osc_s3_q;

    // Guard checks read the stored bits, so upsets trip them as well as writes
    assign guard_key = watchdog_control_q[`WDRC_KEY_MSB:`WDRC_KEY_LSB];
    assign key_ok    = (guard_key == `WDRC_KEY_A) | (guard_key == `WDRC_KEY_B);
    assign code_ok   = (brownout_threshold_select_q == `WDRC_THR_CODE_0) |
                       (brownout_threshold_select_q == `WDRC_THR_CODE_1) |
                       (brownout_threshold_select_q == `WDRC_THR_CODE_2) |
                       (brownout_threshold_select_q == `WDRC_THR_CODE_3);

    assign wdt_last  = wdrc_period_last(watchdog_control_q[`WDRC_PSEL_MSB:`WDRC_PSEL_LSB]);
    assign wdt_ovf   = slow_tick & key_ok & ~sys_reset_q & (wdt_cnt_q == wdt_last);
    assign bo_last   = wdrc_filter_last(filter_time_select_q);
    assign bo_fire   = slow_tick & low_s2_q & ~low_power_mode & (bo_cnt_q == bo_last);
    assign key_fire  = (key_dly_q == `WDRC_FAULT_CYC);
    assign code_fire = (code_dly_q == `WDRC_FAULT_CYC);

    // Overflow in a low-power mode is not a full reset
    assign full_rst  = key_fire | code_fire | bo_fire |
                       (wdt_ovf & ~low_power_mode);

    // Watchdog counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt_q <= 18'h0;
        end else if (clk_en) begin
            if (key_fire || kick_instruction || halt_instruction || sys_reset_q ||
                    wdt_ovf) begin
                wdt_cnt_q <= 18'h0;
            end else if (slow_tick && key_ok) begin
                wdt_cnt_q <= wdt_cnt_q + 18'h1;
            end
        end
    end

    // Brown-out filter: any high supply sample restarts the episode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bo_cnt_q <= 8'h0;
        end else if (clk_en) begin
            if (!low_s2_q || low_power_mode || sys_reset_q || bo_fire) begin
                bo_cnt_q <= 8'h0;
            end else if (slow_tick) begin
                bo_cnt_q <= bo_cnt_q + 8'h1;
            end
        end
    end

    // Fault delays: once started they run out even if the value is repaired,
    // so a glitch that heals itself still leaves a defined reset behind
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_dly_q  <= 8'h0;
            code_dly_q <= 8'h0;
        end else if (clk_en) begin
            if (key_fire) begin
                key_dly_q <= 8'h0;
            end else if (!key_ok || key_dly_q != 8'h0) begin
                key_dly_q <= key_dly_q + 8'h1;
            end
            if (code_fire) begin
                code_dly_q <= 8'h0;
            end else if (!code_ok || code_dly_q != 8'h0) begin
                code_dly_q <= code_dly_q + 8'h1;
            end
        end
    end

    // Reset sequencer: holds the core in reset a few cycles after any cause
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q      <= 3'h0;
            sys_reset_q <= 1'b1;
            pc_sp_clear <= 1'b0;
        end else if (clk_en) begin
            pc_sp_clear <= wdt_ovf & low_power_mode;
            if (full_rst) begin
                hold_q      <= 3'h0;
                sys_reset_q <= 1'b1;
            end else if (sys_reset_q) begin
                if (hold_q == `WDRC_HOLD_CYC - 1) begin
                    sys_reset_q <= 1'b0;
                end
                hold_q <= hold_q + 3'h1;
            end
        end
    end

    // While high the CPU program counter is held at zero
    assign sys_reset = sys_reset_q;

    // Control register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_control_q <= `WDRC_CTRL_RST;
        end else if (clk_en) begin
            if (key_fire || (wdt_ovf && !low_power_mode)) begin
                watchdog_control_q <= `WDRC_CTRL_RST;
            end else if (wr_ctrl) begin
                watchdog_control_q <= pwdata[7:0];
            end
        end
    end

    // Threshold and filter select
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_threshold_select_q <= `WDRC_THR_RST;
            filter_time_select_q        <= `WDRC_FILT_RST;
        end else if (clk_en) begin
            if (code_fire) begin
                brownout_threshold_select_q <= `WDRC_THR_RST;
            end else if (wr_thresh) begin
                brownout_threshold_select_q <= pwdata[7:0];
            end
            if (wr_filter) begin
                filter_time_select_q <= pwdata[1:0];
            end
        end
    end

    // Cause flags: software may only clear; a set in the same cycle wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_cause_flags_q <= `WDRC_CAUSE_RST;
        end else if (clk_en) begin
            reset_cause_flags_q[`WDRC_CAUSE_KEY_BIT] <= key_fire |
                (reset_cause_flags_q[`WDRC_CAUSE_KEY_BIT] &
                 ~(wr_cause & ~pwdata[`WDRC_CAUSE_KEY_BIT]));
            reset_cause_flags_q[`WDRC_CAUSE_CODE_BIT] <= code_fire |
                (reset_cause_flags_q[`WDRC_CAUSE_CODE_BIT] &
                 ~(wr_cause & ~pwdata[`WDRC_CAUSE_CODE_BIT]));
            reset_cause_flags_q[`WDRC_CAUSE_BO_BIT] <= bo_fire |
                (reset_cause_flags_q[`WDRC_CAUSE_BO_BIT] &
                 ~(wr_cause & ~pwdata[`WDRC_CAUSE_BO_BIT]));
        end
    end

    // Expired and power-down status; hardware events outrank instruction clears
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_expired_flag_q <= 1'b0;
            powerdown_flag_q        <= 1'b0;
        end else if (clk_en) begin
            if (wdt_ovf) begin
                watchdog_expired_flag_q <= 1'b1;
            end else if (kick_instruction || halt_instruction) begin
                watchdog_expired_flag_q <= 1'b0;
            end
            if (halt_instruction) begin
                powerdown_flag_q <= 1'b1;
            end else if (kick_instruction) begin
                powerdown_flag_q <= 1'b0;
            end
        end
    end

    // Port registers start as inputs; only power-on restores them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_data_q <= `WDRC_PORT_RST;
            port_dir_q  <= `WDRC_PORT_RST;
        end else if (clk_en) begin
            if (wr_pdata) begin
                port_data_q <= pwdata[7:0];
            end
            if (wr_pdir) begin
                port_dir_q <= pwdata[7:0];
            end
        end
    end

    assign port_data = port_data_q;
    assign port_dir  = port_dir_q;

endmodule // wdrc_core

// ---- design/wdrc_regs.vh ----
// Offsets, field positions, reset values and timing counts of the watchdog and reset block
`ifndef WDRC_REGS_VH
`define WDRC_REGS_VH

`define WDRC_OFF_CTRL        8'h00
`define WDRC_OFF_CAUSE       8'h04
`define WDRC_OFF_THRESH      8'h08
`define WDRC_OFF_FILTER      8'h0c
`define WDRC_OFF_STATUS      8'h10
`define WDRC_OFF_PORT_DATA   8'h14
`define WDRC_OFF_PORT_DIR    8'h18

`define WDRC_KEY_MSB         7
`define WDRC_KEY_LSB         3
`define WDRC_PSEL_MSB        2
`define WDRC_PSEL_LSB        0
`define WDRC_KEY_A           5'h0a
`define WDRC_KEY_B           5'h15
`define WDRC_CTRL_RST        8'h53

`define WDRC_CAUSE_KEY_BIT   0
`define WDRC_CAUSE_CODE_BIT  1
`define WDRC_CAUSE_BO_BIT    2
`define WDRC_CAUSE_RST       3'h0

`define WDRC_THR_CODE_0      8'h55
`define WDRC_THR_CODE_1      8'h33
`define WDRC_THR_CODE_2      8'h99
`define WDRC_THR_CODE_3      8'haa
`define WDRC_THR_RST         8'h55
`define WDRC_FILT_RST        2'h1

`define WDRC_STAT_EXP_BIT    0
`define WDRC_STAT_PD_BIT     1
`define WDRC_STAT_RST_BIT    2
`define WDRC_PORT_RST        8'hff

`define WDRC_CLK_PERIOD_NS   10
`define WDRC_FAULT_DLY_NS    1000
`define WDRC_FAULT_CYC       (`WDRC_FAULT_DLY_NS / `WDRC_CLK_PERIOD_NS)
`define WDRC_HOLD_CYC        4

`endif

// ---- testbench/wdrc_asserts.sv ----
// Port-level assertions for the watchdog and reset block
`timescale 1ns/1ps
`include "wdrc_regs.vh"

module wdrc_asserts (
    input logic        pclk,
    input logic        presetn,
    input logic        clk_en,
    input logic        psel,
    input logic        penable,
    input logic [7:0]  paddr,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        low_power_mode,
    input logic        sys_reset,
    input logic        pc_sp_clear,
    input logic [7:0]  port_data,
    input logic [7:0]  port_dir
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Misaligned or past the last register counts as unmapped
    wire unmapped = (paddr > `WDRC_OFF_PORT_DIR) || (paddr[1:0] != 2'h0);
    wire setup    = psel && !penable && clk_en;

    AST_PREADY_EN:
        assert property (pready == clk_en) else $error("pready differs from clk_en");
    AST_ERR_UNMAPPED:
        assert property (psel && penable && unmapped |-> pslverr)
        else $error("no error on unmapped access");
    AST_ERR_PHASE:
        assert property (pslverr |-> psel && penable && unmapped)
        else $error("error outside unmapped access phase");
    AST_UNMAPPED_ZERO:
        assert property (setup && unmapped |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    AST_CAUSE_HI_ZERO:
        assert property (setup && paddr == `WDRC_OFF_CAUSE |=> prdata[31:3] == 29'h0)
        else $error("cause upper bits not zero");
    AST_POR_RELEASE:
        assert property ($rose(presetn) |-> sys_reset [*4] ##1 !sys_reset)
        else $error("core reset hold after power-on wrong");
    AST_PORTS_POR:
        assert property ($rose(presetn) |-> port_data == 8'hff && port_dir == 8'hff)
        else $error("ports not all ones after power-on");
    AST_RST_HOLD:
        assert property ($rose(sys_reset) |-> sys_reset [*4] ##1 !sys_reset)
        else $error("core reset pulse length wrong");
    AST_PCSP_ONE:
        assert property (pc_sp_clear |=> !pc_sp_clear)
        else $error("counter clear pulse longer than one cycle");
    AST_PCSP_LP:
        assert property (pc_sp_clear |-> !sys_reset && $past(low_power_mode))
        else $error("counter clear outside low-power mode");
endmodule // wdrc_asserts

bind wdrc_core wdrc_asserts u_chk (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_power_mode(low_power_mode), .sys_reset(sys_reset), .pc_sp_clear(pc_sp_clear),
    .port_data(port_data), .port_dir(port_dir));

// ---- testbench/wdrc_tb.sv ----
// Self-checking bench for the watchdog and reset block
`timescale 1ns/1ps
`include "wdrc_regs.vh"

module tb_top;
    typedef struct packed {logic [7:0] a; logic w; logic [31:0] d, x; logic e;} wdrc_row_t;
    logic        pclk;
    logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, sys_reset, pc_sp_clear, rst_prev;
    logic        slow_osc = 1'b0, supply_low = 1'b0, lp_mode = 1'b0, kick = 1'b0, halt = 1'b0;
    logic [7:0]  port_data, port_dir;
    logic        clk_en = 1'b1;
    int          bad_count, num_checks, n, base, rst_cnt = 0, pcsp_cnt = 0;
    wdrc_row_t   rows [0:19] = '{
        '{`WDRC_OFF_CTRL, 0, 0, 32'h53, 0}, '{`WDRC_OFF_CAUSE, 0, 0, 0, 0},
        '{`WDRC_OFF_THRESH, 0, 0, 32'h55, 0}, '{`WDRC_OFF_FILTER, 0, 0, 32'h1, 0},
        '{`WDRC_OFF_PORT_DATA, 0, 0, 32'hff, 0}, '{`WDRC_OFF_PORT_DIR, 0, 0, 32'hff, 0},
        '{`WDRC_OFF_CAUSE, 1, 32'hffffffff, 0, 0}, '{`WDRC_OFF_CAUSE, 0, 0, 0, 0},
        '{`WDRC_OFF_FILTER, 1, 32'h3, 0, 0}, '{`WDRC_OFF_FILTER, 0, 0, 32'h3, 0},
        '{8'h1c, 1, 32'h5a, 0, 1}, '{8'h1c, 0, 0, 0, 1},
        '{`WDRC_OFF_THRESH, 1, 32'h33, 0, 0}, '{`WDRC_OFF_THRESH, 0, 0, 32'h33, 0},
        '{`WDRC_OFF_THRESH, 1, 32'h99, 0, 0}, '{`WDRC_OFF_THRESH, 0, 0, 32'h99, 0},
        '{`WDRC_OFF_THRESH, 1, 32'haa, 0, 0}, '{`WDRC_OFF_THRESH, 0, 0, 32'haa, 0},
        '{`WDRC_OFF_THRESH, 1, 32'h55, 0, 0}, '{`WDRC_OFF_STATUS, 0, 0, 0, 0}};

    wdrc_core uut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slow_internal_osc(slow_osc), .supply_low(supply_low),
        .low_power_mode(lp_mode), .kick_instruction(kick), .halt_instruction(halt),
        .sys_reset(sys_reset), .pc_sp_clear(pc_sp_clear), .port_data(port_data),
        .port_dir(port_dir));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (sys_reset === 1'b1 && rst_prev !== 1'b1) rst_cnt <= rst_cnt + 1;
        if (pc_sp_clear === 1'b1) pcsp_cnt <= pcsp_cnt + 1;
        rst_prev <= sys_reset;
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Starts one edge late so back-to-back calls never drive psel twice in a step
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench watchdog ends a wait that never completes
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdx(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        check(rd, exp);
    endtask

    task tick(input int t);
        repeat (t) begin
            @(posedge pclk);
            slow_osc <= 1'b1;
            repeat (3) @(posedge pclk);
            slow_osc <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask

    task pulse(input logic h);
        @(posedge pclk);
        kick <= !h;
        halt <= h;
        @(posedge pclk);
        kick <= 1'b0;
        halt <= 1'b0;
    endtask

    // Fault resets come a fixed delay after the bad value is stored
    task fault_wait();
        n = 0;
        while (sys_reset !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        repeat (8) @(posedge pclk);
    endtask

    task test_done();
        if (bad_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        test_done();
    end

    initial begin
        bad_count = 0;
        num_checks = 0;
        repeat (6) @(posedge pclk);
        check({sys_reset, port_dir, port_data}, 17'h1ffff);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        check(sys_reset, 0);
        for (int i = 0; i < 20; i++) begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w) check(rd, rows[i].x);
            check(er, rows[i].e);
        end
        repeat (150) @(posedge pclk);
        check(rst_cnt, 1);
        apb(`WDRC_OFF_CTRL, 1'b1, 32'ha8);
        tick(200);
        pulse(1'b0);
        tick(255);
        check(rst_cnt, 1);
        tick(1);
        repeat (8) @(posedge pclk);
        check(rst_cnt, 2);
        rdx(`WDRC_OFF_STATUS, 32'h1);
        rdx(`WDRC_OFF_CTRL, 32'h53);
        apb(`WDRC_OFF_CTRL, 1'b1, 32'ha8);
        lp_mode <= 1'b1;
        tick(200);
        pulse(1'b1);
        tick(255);
        check(pcsp_cnt, 0);
        tick(1);
        check(rst_cnt, 2);
        check(pcsp_cnt, 1);
        rdx(`WDRC_OFF_STATUS, 32'h3);
        // Shortest filter, so a supervisor left on in sleep would surely fire
        apb(`WDRC_OFF_FILTER, 1'b1, 32'h0);
        supply_low <= 1'b1;
        tick(20);
        supply_low <= 1'b0;
        check(rst_cnt, 2);
        lp_mode <= 1'b0;
        pulse(1'b0);
        rdx(`WDRC_OFF_STATUS, 32'h0);
        apb(`WDRC_OFF_THRESH, 1'b1, 32'h99);
        supply_low <= 1'b1;
        tick(7);
        supply_low <= 1'b0;
        repeat (6) @(posedge pclk);
        check(rst_cnt, 2);
        supply_low <= 1'b1;
        tick(8);
        supply_low <= 1'b0;
        repeat (10) @(posedge pclk);
        check(rst_cnt, 3);
        rdx(`WDRC_OFF_CAUSE, 32'h4);
        rdx(`WDRC_OFF_THRESH, 32'h99);
        apb(`WDRC_OFF_CAUSE, 1'b1, 32'h0);
        apb(`WDRC_OFF_CTRL, 1'b1, 32'h0);
        fault_wait();
        check(n >= 95 && n <= 110, 1);
        rdx(`WDRC_OFF_CAUSE, 32'h1);
        rdx(`WDRC_OFF_CTRL, 32'h53);
        apb(`WDRC_OFF_CAUSE, 1'b1, 32'h0);
        apb(`WDRC_OFF_THRESH, 1'b1, 32'h12);
        fault_wait();
        check(n >= 95 && n <= 110, 1);
        rdx(`WDRC_OFF_CAUSE, 32'h2);
        rdx(`WDRC_OFF_THRESH, 32'h55);
        // Enable low stretches the access phase; the write lands once it returns
        clk_en <= 1'b0;
        fork
            apb(`WDRC_OFF_PORT_DATA, 1'b1, 32'h5a);
            begin
                repeat (4) @(posedge pclk);
                check(pready, 0);
                clk_en <= 1'b1;
            end
        join
        rdx(`WDRC_OFF_PORT_DATA, 32'h5a);
        test_done();
    end
endmodule // tb_top
